// ### design/aomsel_cmp.sv
// per-field signed compare of a result against its two limits
module aomsel_cmp (
  input wire aomsel_pkg::aomsel_vec_t result,
  input wire aomsel_pkg::aomsel_vec_t lim_lo,
  input wire aomsel_pkg::aomsel_vec_t lim_hi,
  aomsel_cmp_if.src cmp
);
  // ---------------------------------------------------------------
  // compare
  // ---------------------------------------------------------------
  // a blank limit or a missing result never counts as exceeded
  for (genvar i = 0; i < aomsel_pkg::NLIM; i++) begin : g_f
    logic res_ok;
    assign res_ok = result[i] != aomsel_pkg::NULL_VALUE;
    assign cmp.lo_set[i] = lim_lo[i] != aomsel_pkg::NULL_VALUE;
    assign cmp.hi_set[i] = lim_hi[i] != aomsel_pkg::NULL_VALUE;
    assign cmp.above_lo[i] = res_ok && cmp.lo_set[i] &&
      ($signed(result[i]) > $signed(lim_lo[i]));
    assign cmp.above_hi[i] = res_ok && cmp.hi_set[i] &&
      ($signed(result[i]) > $signed(lim_hi[i]));
  end
endmodule

// ### design/aomsel_cmp_if.sv
// carrier of per-field compare flags between the comparator and the top
interface aomsel_cmp_if;
  logic [aomsel_pkg::NLIM-1:0] above_lo;
  logic [aomsel_pkg::NLIM-1:0] above_hi;
  logic [aomsel_pkg::NLIM-1:0] lo_set;
  logic [aomsel_pkg::NLIM-1:0] hi_set;
  modport src (output above_lo, output above_hi, output lo_set,
    output hi_set);
  modport dst (input above_lo, input above_hi, input lo_set,
    input hi_set);
endinterface

// ### design/aomsel_pkg.sv
// shared constants and types for the alarm output mode selector
package aomsel_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned NCODE = 8;
  localparam int unsigned CW = 16;
  localparam int unsigned MW = 3;
  localparam int unsigned NLIM = 10;

  // ---------------------------------------------------------------
  // mode encodings
  // ---------------------------------------------------------------
  localparam logic [MW-1:0] MODE_WARN_ALARM = 3'h0;
  localparam logic [MW-1:0] MODE_CLEAN_DIRTY = 3'h1;
  localparam logic [MW-1:0] MODE_GREEN_RED = 3'h2;
  localparam logic [MW-1:0] MODE_PART_WATER = 3'h3;
  localparam logic [MW-1:0] MODE_CONT_CLEAN = 3'h4;
  localparam logic [MW-1:0] MODE_TESTED = 3'h5;
  localparam logic [MW-1:0] MODE_TESTING = 3'h6;

  // ---------------------------------------------------------------
  // field positions of the limit vector: codes, then water, then temp
  // ---------------------------------------------------------------
  localparam int unsigned IDX_WATER = 8;
  localparam int unsigned IDX_TEMP = 9;

  // null / no result marker on a result word
  localparam logic [CW-1:0] NULL_VALUE = 16'h8000;

  typedef logic [NLIM-1:0][CW-1:0] aomsel_vec_t;

  typedef struct packed {
    logic out1;
    logic out2;
    logic run;
    logic done;
  } aomsel_state_t;
endpackage

// ### design/aomsel_top.sv
// alarm output mode selector: drives two switched outputs from results, output 1 from test status in the test modes
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module aomsel_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [aomsel_pkg::MW-1:0] mode,
  input wire aomsel_pkg::aomsel_vec_t result,
  input wire aomsel_pkg::aomsel_vec_t lim_lo,
  input wire aomsel_pkg::aomsel_vec_t lim_hi,
  input wire logic result_valid,
  input wire logic test_running,
  input wire logic test_started,
  output logic alarm_out1,
  output logic alarm_out2
);
  localparam int unsigned N = aomsel_pkg::NLIM;

  aomsel_cmp_if cmp_bus ();

  aomsel_cmp u_cmp (
    .result(result),
    .lim_lo(lim_lo),
    .lim_hi(lim_hi),
    .cmp(cmp_bus)
  );

  // ---------------------------------------------------------------
  // combined conditions
  // ---------------------------------------------------------------
  logic [N-1:0] part_mask;
  logic any_lo;
  logic any_hi;
  logic all_le_lo;
  logic any_lo_set;
  logic part_hi;
  logic part_le_lo;
  logic water_hi;
  logic water_le_lo;

  always_comb begin
    part_mask = '0;
    part_mask[aomsel_pkg::NCODE-1:0] = '1;
  end

  assign any_lo = |cmp_bus.above_lo;
  assign any_hi = |cmp_bus.above_hi;
  assign any_lo_set = |cmp_bus.lo_set;
  // "at or below" needs at least one set limit, else it reads false
  assign all_le_lo = any_lo_set && !any_lo;
  assign part_hi = |(cmp_bus.above_hi & part_mask);
  assign part_le_lo = |(cmp_bus.lo_set & part_mask) &&
    !(|(cmp_bus.above_lo & part_mask));
  assign water_hi = cmp_bus.above_hi[aomsel_pkg::IDX_WATER];
  assign water_le_lo = cmp_bus.lo_set[aomsel_pkg::IDX_WATER] &&
    !cmp_bus.above_lo[aomsel_pkg::IDX_WATER];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  aomsel_pkg::aomsel_state_t s_q;
  aomsel_pkg::aomsel_state_t s_d;

  always_comb begin
    s_d = s_q;
    // test tracking: completion latched on the falling edge of running;
    // a start in the same cycle wins so a stale completion never shows
    s_d.run = test_running;
    if (test_started) begin
      s_d.done = 1'b0;
    end else if (s_q.run && !test_running) begin
      s_d.done = 1'b1;
    end
    if (result_valid) begin
      case (mode)
        aomsel_pkg::MODE_WARN_ALARM: begin
          s_d.out1 = any_lo;
          s_d.out2 = any_hi;
        end
        aomsel_pkg::MODE_CLEAN_DIRTY: begin
          s_d.out1 = all_le_lo;
          s_d.out2 = any_hi;
        end
        aomsel_pkg::MODE_GREEN_RED: begin
          s_d.out1 = |cmp_bus.hi_set && !any_hi;
          s_d.out2 = any_lo;
        end
        aomsel_pkg::MODE_PART_WATER: begin
          // hysteresis: hold between the two limits
          if (part_hi) begin
            s_d.out1 = 1'b1;
          end else if (part_le_lo) begin
            s_d.out1 = 1'b0;
          end
          if (water_hi) begin
            s_d.out2 = 1'b1;
          end else if (water_le_lo) begin
            s_d.out2 = 1'b0;
          end
        end
        aomsel_pkg::MODE_CONT_CLEAN: begin
          s_d.out1 = any_lo;
          s_d.out2 = all_le_lo;
        end
        aomsel_pkg::MODE_TESTED: begin
          s_d.out2 = any_lo;
        end
        aomsel_pkg::MODE_TESTING: begin
          s_d.out2 = any_lo;
        end
        default: begin
          s_d.out1 = 1'b0;
          s_d.out2 = 1'b0;
        end
      endcase
    end
    // output 1 in the test modes follows test status, not results
    if (mode == aomsel_pkg::MODE_TESTED) begin
      s_d.out1 = s_d.done;
    end else if (mode == aomsel_pkg::MODE_TESTING) begin
      s_d.out1 = test_running;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // only the two switched outputs exist here; no panel indicator path
  assign alarm_out1 = s_q.out1;
  assign alarm_out2 = s_q.out2;
endmodule

// ### tb/aomsel_lamp.sv
// three-colour lamp that stands on the two alarm outputs
module aomsel_lamp (
  input wire logic alarm_out1,
  input wire logic alarm_out2,
  output logic [1:0] lamp
);
  // bit 0 green, bit 1 red; both lit reads as amber
  assign lamp = {alarm_out2, alarm_out1};
endmodule

// ### tb/aomsel_top_sva.sv
// assertion checker for the alarm output mode selector
module aomsel_top_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic [aomsel_pkg::MW-1:0] mode,
  input wire aomsel_pkg::aomsel_vec_t result,
  input wire aomsel_pkg::aomsel_vec_t lim_lo,
  input wire aomsel_pkg::aomsel_vec_t lim_hi,
  input wire logic result_valid,
  input wire logic test_running,
  input wire logic test_started,
  input wire logic alarm_out1,
  input wire logic alarm_out2
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic lo0, hi0, rv;
  // field 0 alone is enough: any one exceeded limit must turn on
  assign lo0 = result[0] != 16'h8000 && lim_lo[0] != 16'h8000 &&
    $signed(result[0]) > $signed(lim_lo[0]);
  assign hi0 = result[0] != 16'h8000 && lim_hi[0] != 16'h8000 &&
    $signed(result[0]) > $signed(lim_hi[0]);
  assign rv = result_valid;
  a_warn_lower:
    assert property (rv && mode == 3'h0 && lo0 |=> alarm_out1)
    else $error("warning output missed");
  a_warn_upper:
    assert property (rv && mode == 3'h0 && hi0 |=> alarm_out2)
    else $error("alarm output missed");
  a_dirty_upper:
    assert property (rv && mode == 3'h1 && hi0 |=> alarm_out2)
    else $error("dirty output missed");
  a_cont_excl:
    assert property (rv && mode == 3'h4 && lim_lo[0] != 16'h8000
    |=> alarm_out1 != alarm_out2)
    else $error("continue and clean not exclusive");
  a_blank_off:
    assert property (rv && mode == 3'h0 &&
    lim_lo == {10{16'h8000}} |=> !alarm_out1)
    else $error("blank lower limits turned output on");
  a_resv_off:
    assert property (rv && mode == 3'h7 |=> !(alarm_out1 || alarm_out2))
    else $error("reserved mode left an output on");
  a_test_done:
    assert property ($fell(test_running) && mode == 3'h5 &&
    !test_started |=> alarm_out1)
    else $error("test complete output missed");
  a_testing_track:
    assert property (mode == 3'h6 |=> alarm_out1 == $past(test_running))
    else $error("testing output does not follow test");
  a_hold_out2:
    assert property (!rv |=> $stable(alarm_out2))
    else $error("output 2 moved without a result");
endmodule
bind aomsel_top aomsel_top_sva aomsel_top_sva_inst (.clock(clock), .rst(rst),
  .mode(mode), .result(result), .lim_lo(lim_lo), .lim_hi(lim_hi),
  .result_valid(result_valid), .test_running(test_running),
  .test_started(test_started), .alarm_out1(alarm_out1),
  .alarm_out2(alarm_out2));

// ### tb/aomsel_top_test.sv
// self-checking bench for the alarm output mode selector
module aomsel_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] NV = 16'h8000;
  logic clock, rst, rv, tr, ts, o1, o2;
  logic [2:0] mode;
  logic [1:0] lamp;
  aomsel_pkg::aomsel_vec_t res, lo, hi;
  int bad_count, num_checks;
  aomsel_top aomsel_top_inst (.clock(clock), .rst(rst), .mode(mode),
    .result(res), .lim_lo(lo), .lim_hi(hi), .result_valid(rv),
    .test_running(tr), .test_started(ts), .alarm_out1(o1),
    .alarm_out2(o2));
  aomsel_lamp aomsel_lamp_inst (.alarm_out1(o1), .alarm_out2(o2),
    .lamp(lamp));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one result pulse, outputs judged 1 ns after the edge that takes it
  task automatic apply(input logic [2:0] m, input logic [15:0] a,
    input logic [15:0] b, input logic [1:0] e);
    step(1);
    mode = m;
    res[0] = a;
    res[8] = b;
    rv = 1'b1;
    step(1);
    rv = 1'b0;
    chk("outputs", e, {o1, o2});
  endtask
  task automatic t_limits;
    apply(3'h0, 16'h000b, NV, 2'b10);
    apply(3'h0, 16'h0015, NV, 2'b11);
    apply(3'h0, NV, 16'h00c9, 2'b11);
    apply(3'h1, 16'h000a, NV, 2'b10);
    apply(3'h1, 16'h0014, NV, 2'b00);
    apply(3'h1, 16'h0015, NV, 2'b01);
    apply(3'h4, 16'h000b, NV, 2'b10);
    apply(3'h4, 16'h000a, NV, 2'b01);
    $display("t_limits done");
  endtask
  task automatic t_gar;
    apply(3'h2, 16'h000f, NV, 2'b11);
    chk("lamp", 2'b11, lamp);
    apply(3'h2, 16'h0009, NV, 2'b10);
    apply(3'h2, 16'h0015, NV, 2'b01);
    $display("t_gar done");
  endtask
  task automatic t_part;
    apply(3'h3, 16'h0015, 16'h00c9, 2'b11);
    apply(3'h3, 16'h000f, 16'h0096, 2'b11);
    apply(3'h3, 16'h000a, 16'h0064, 2'b00);
    apply(3'h3, 16'h000f, 16'h0096, 2'b00);
    // single threshold: equal limits turn hysteresis into one level
    {lo[0], hi[0]} = {16'h000f, 16'h000f};
    apply(3'h3, 16'h0010, 16'h0064, 2'b10);
    apply(3'h3, 16'h000f, 16'h0064, 2'b00);
    {lo[0], hi[0]} = {16'h000a, 16'h0014};
    $display("t_part done");
  endtask
  task automatic t_test;
    apply(3'h5, 16'h000b, NV, 2'b01);
    // one test per start, never a continuous run in the test modes
    tr = 1'b1;
    step(3);
    tr = 1'b0;
    step(2);
    chk("complete", 2'b11, {o1, o2});
    ts = 1'b1;
    step(1);
    ts = 1'b0;
    step(1);
    chk("restart", 2'b01, {o1, o2});
    apply(3'h6, 16'h0009, NV, 2'b00);
    tr = 1'b1;
    step(2);
    chk("testing", 2'b10, {o1, o2});
    tr = 1'b0;
    step(2);
    chk("test end", 2'b00, {o1, o2});
    $display("t_test done");
  endtask
  task automatic t_resv;
    apply(3'h7, 16'h0015, NV, 2'b00);
    lo = {10{NV}};
    apply(3'h0, 16'h0015, NV, 2'b01);
    $display("t_resv done");
  endtask
  initial begin
    {rst, rv, tr, ts, mode, bad_count, num_checks} = '0;
    rst = 1'b1;
    res = {10{NV}};
    lo = {10{NV}};
    hi = {10{NV}};
    {lo[0], hi[0], lo[8], hi[8]} = {16'h000a, 16'h0014, 16'h0064, 16'h00c8};
    step(2);
    rst = 1'b0;
    t_limits();
    t_gar();
    t_part();
    t_test();
    t_resv();
    stop_test();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #20000;
    bad_count++;
    stop_test();
  end
endmodule
